/* File: rtl/adcseq_top.sv */
// Purpose: Conversion sequencing for a delta-sigma converter
// Assumes: Modulator word on MOD_DATA is sampled once per conversion period on CLK
// Notes: Period register sets cycles per conversion
`timescale 1ns/100ps
`include "adcseq_regs.svh"
module adcseq_top
  import adcseq_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic SRST,
  // Register port
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  // Modulator stream
  input wire logic [11:0] MOD_DATA,
  // Conversion handshake
  input wire logic CONVERSION_TRIGGER_IN,
  output logic CONVERSION_DONE_OUT,
  output logic MOD_RESET
);
  adcseq_bus_s bus;
  adcseq_state_e state_r, state_nxt;
  adcseq_mode_e mode_r;
  logic res8_r;
  logic [15:0] div_r;
  logic [15:0] tick_cnt_r;
  logic conv_end;
  logic [1:0] prime_r;
  logic [1:0] mux_cnt_r;
  logic mux_valid_r;
  logic [11:0] tap_r [0:3];
  logic [13:0] sum;
  logic [11:0] result_r;
  logic done_r;
  logic trig_s1_r, trig_s2_r, trig_d_r;
  logic trig_rise;
  logic start_w;
  logic res_read;
  logic new_result;
  logic mod_reset_r;

  assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  // Trigger synchroniser and edge detect
  always_ff @(posedge CLK) begin
    if (SRST) begin
      trig_s1_r <= 1'b0;
      trig_s2_r <= 1'b0;
      trig_d_r <= 1'b0;
    end else begin
      trig_s1_r <= CONVERSION_TRIGGER_IN;
      trig_s2_r <= trig_s1_r;
      trig_d_r <= trig_s2_r;
    end
  end
  assign trig_rise = trig_s2_r & ~trig_d_r;
  assign start_w = (bus.wr && bus.addr == `ADCSEQ_OFF_CTRL
                    && bus.wdata[`ADCSEQ_CTRL_START]) || trig_rise;
  assign res_read = bus.rd && bus.addr == `ADCSEQ_OFF_RES;

  // Control registers
  always_ff @(posedge CLK) begin
    if (SRST) begin
      mode_r <= ADCSEQ_SINGLE;
      res8_r <= 1'b0;
      div_r <= `ADCSEQ_DIV_RST;
    end else if (bus.wr && bus.addr == `ADCSEQ_OFF_CTRL) begin
      mode_r <= adcseq_mode_e'(bus.wdata[`ADCSEQ_CTRL_MODE_LO +: 2]);
      res8_r <= bus.wdata[`ADCSEQ_CTRL_RES8];
    end else if (bus.wr && bus.addr == `ADCSEQ_OFF_DIV) begin
      if (bus.wdata[`ADCSEQ_CTRL_RES8 - 3 +: 16] < (res8_r ? `ADCSEQ_SMP8_MIN
          : `ADCSEQ_SMP12_MIN))
        div_r <= res8_r ? `ADCSEQ_SMP8_MIN : `ADCSEQ_SMP12_MIN;
      else
        div_r <= bus.wdata;
    end
  end

  // Conversion period counter
  always_ff @(posedge CLK) begin
    if (SRST || state_r == ADCSEQ_IDLE || state_r == ADCSEQ_WAIT)
      tick_cnt_r <= 16'h0000;
    else if (conv_end)
      tick_cnt_r <= 16'h0000;
    else
      tick_cnt_r <= tick_cnt_r + 16'h0001;
  end
  assign conv_end = (state_r == ADCSEQ_PRIME || state_r == ADCSEQ_RUN)
                    && tick_cnt_r == div_r;

  // Sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ADCSEQ_IDLE: begin
        if (start_w)
          state_nxt = ADCSEQ_PRIME;
      end
      ADCSEQ_PRIME: begin
        if (conv_end && prime_r == `ADCSEQ_PRIME_CNT - 2'h1)
          state_nxt = ADCSEQ_RUN;
      end
      ADCSEQ_RUN: begin
        if (conv_end) begin
          case (mode_r)
            ADCSEQ_SINGLE: state_nxt = ADCSEQ_WAIT;
            ADCSEQ_CONT: state_nxt = ADCSEQ_RUN;
            default: state_nxt = ADCSEQ_PRIME;
          endcase
        end
      end
      ADCSEQ_WAIT: begin
        if (res_read || !done_r)
          state_nxt = ADCSEQ_IDLE;
      end
      default: state_nxt = ADCSEQ_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SRST)
      state_r <= ADCSEQ_IDLE;
    else
      state_r <= state_nxt;
  end

  // Priming count
  always_ff @(posedge CLK) begin
    if (SRST || state_r != ADCSEQ_PRIME)
      prime_r <= 2'h0;
    else if (conv_end)
      prime_r <= prime_r + 2'h1;
  end

  // Modulator reset in idle and between multi and turbo samples
  always_ff @(posedge CLK) begin
    if (SRST)
      mod_reset_r <= 1'b1;
    else
      mod_reset_r <= state_nxt == ADCSEQ_IDLE
                     || (state_r == ADCSEQ_RUN && state_nxt == ADCSEQ_PRIME);
  end

  // Decimator taps
  always_ff @(posedge CLK) begin
    if (SRST || mod_reset_r) begin
      for (int i = 0; i < 4; i++)
        tap_r[i] <= 12'h000;
    end else if (conv_end) begin
      tap_r[0] <= MOD_DATA;
      for (int i = 1; i < 4; i++)
        tap_r[i] <= tap_r[i-1];
    end
  end
  assign sum = {2'b00, tap_r[0]} + {2'b00, tap_r[1]} + {2'b00, tap_r[2]}
               + {2'b00, MOD_DATA};
  assign new_result = state_r == ADCSEQ_RUN && conv_end;

  // Mux change validity
  always_ff @(posedge CLK) begin
    if (SRST) begin
      mux_cnt_r <= 2'h0;
      mux_valid_r <= 1'b1;
    end else if (bus.wr && bus.addr == `ADCSEQ_OFF_CTRL
                 && bus.wdata[`ADCSEQ_CTRL_MUXCHG]) begin
      mux_cnt_r <= 2'h0;
      mux_valid_r <= 1'b0;
    end else if (conv_end && !mux_valid_r) begin
      mux_cnt_r <= mux_cnt_r + 2'h1;
      mux_valid_r <= mux_cnt_r == 2'h3;
    end
  end

  // Result and done
  always_ff @(posedge CLK) begin
    if (SRST)
      result_r <= 12'h000;
    else if (new_result)
      result_r <= res8_r ? {4'h0, sum[13:6]} : sum[13:2];
  end

  always_ff @(posedge CLK) begin
    if (SRST)
      done_r <= 1'b0;
    else if (new_result)
      done_r <= 1'b1;
    else if (res_read)
      done_r <= 1'b0;
  end

  // Outputs
  always_ff @(posedge CLK) begin
    if (SRST) begin
      CONVERSION_DONE_OUT <= 1'b0;
      MOD_RESET <= 1'b1;
    end else begin
      CONVERSION_DONE_OUT <= new_result || (done_r && !res_read);
      MOD_RESET <= mod_reset_r;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST)
      RDATA <= 16'h0000;
    else if (bus.rd) begin
      case (bus.addr)
        `ADCSEQ_OFF_CTRL: RDATA <= {11'h000, 1'b0, res8_r, mode_r, 1'b0};
        `ADCSEQ_OFF_STAT: RDATA <= {13'h0000, mux_valid_r,
                                    state_r != ADCSEQ_IDLE, done_r};
        `ADCSEQ_OFF_RES: RDATA <= {4'h0, result_r};
        `ADCSEQ_OFF_DIV: RDATA <= div_r;
        default: RDATA <= 16'h0000;
      endcase
    end else
      RDATA <= 16'h0000;
  end
endmodule : adcseq_top

/* File: rtl/adcseq_regs.svh */
// Purpose: Register offsets, fields and timing counts of the conversion sequencer
// Assumes: Word-indexed plain register port
// Notes: Constants only
`ifndef ADCSEQ_REGS_SVH
`define ADCSEQ_REGS_SVH
`define ADCSEQ_ADDR_W 4
`define ADCSEQ_OFF_CTRL 4'h0
`define ADCSEQ_OFF_STAT 4'h1
`define ADCSEQ_OFF_RES 4'h2
`define ADCSEQ_OFF_DIV 4'h3
`define ADCSEQ_CTRL_START 0
`define ADCSEQ_CTRL_MODE_LO 1
`define ADCSEQ_CTRL_RES8 3
`define ADCSEQ_CTRL_MUXCHG 4
`define ADCSEQ_STAT_DONE 0
`define ADCSEQ_STAT_BUSY 1
`define ADCSEQ_STAT_VALID 2
`define ADCSEQ_PRIME_CNT 2'h3
`define ADCSEQ_DIV_RST 16'h00cf
`define ADCSEQ_SMP12_MIN 16'h00cf
`define ADCSEQ_SMP8_MIN 16'h0067
`endif

/* File: rtl/adcseq_pkg.sv */
// Purpose: Types of the conversion sequencer
// Assumes: Constants live in adcseq_regs.svh
// Notes: None
package adcseq_pkg;
  typedef enum logic [1:0] {
    ADCSEQ_SINGLE = 2'b00,
    ADCSEQ_MULTI = 2'b01,
    ADCSEQ_CONT = 2'b10,
    ADCSEQ_TURBO = 2'b11
  } adcseq_mode_e;
  typedef enum logic [1:0] {
    ADCSEQ_IDLE = 2'b00,
    ADCSEQ_PRIME = 2'b01,
    ADCSEQ_RUN = 2'b10,
    ADCSEQ_WAIT = 2'b11
  } adcseq_state_e;
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } adcseq_bus_s;
endpackage : adcseq_pkg

/* File: tb/adcseq_dma_model.sv */
// Purpose: DMA style reader of results
// Assumes: RES at index 2
// Notes: Reads five cycles after done
`timescale 1ns/100ps
module adcseq_dma_model (
  // Control
  input wire logic clk,
  input wire logic en,
  // Device side
  input wire logic done,
  output logic rd,
  output int reads
);
  logic [2:0] wait_r;
  logic pend_r;
  initial begin
    rd = 1'b0;
    wait_r = 3'h0;
    pend_r = 1'b0;
    reads = 0;
  end
  always @(posedge clk) begin
    rd <= (wait_r == 3'h4);
    pend_r <= rd;
    if (pend_r) reads <= reads + 1;
    wait_r <= (en && done && !rd && !pend_r) ? wait_r + 3'h1 : 3'h0;
  end
endmodule : adcseq_dma_model

/* File: tb/adcseq_top_sva.sv */
// Purpose: Port checks of the sequencer
// Assumes: Default 208 cycle conversion
// Notes: Bound in the bench top
`timescale 1ns/100ps
module adcseq_top_sva (
  // Watched ports
  input wire logic CLK,
  input wire logic SRST,
  input wire logic [3:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [15:0] RDATA,
  input wire logic CONVERSION_TRIGGER_IN,
  input wire logic CONVERSION_DONE_OUT,
  input wire logic MOD_RESET
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  logic [15:0] run_r;
  logic mr_q_r;
  logic rd_res;
  assign rd_res = RD && (ADDR == 4'h2);
  always_ff @(posedge CLK) begin
    mr_q_r <= MOD_RESET;
    if (SRST) run_r <= 16'h0;
    else if (!MOD_RESET) run_r <= mr_q_r ? 16'h1 : run_r + {15'h0, run_r != 16'hffff};
  end
  a_reset_state: assert property (disable iff (1'b0)
    SRST |=> RDATA == 16'h0 && !CONVERSION_DONE_OUT && MOD_RESET) else $error("bad reset");
  a_rdata_idle: assert property (!RD |=> RDATA == 16'h0) else $error("rdata not zero");
  a_done_hold: assert property (CONVERSION_DONE_OUT && !rd_res && !$past(rd_res)
    |=> CONVERSION_DONE_OUT) else $error("done dropped");
  a_read_clear: assert property (rd_res && CONVERSION_DONE_OUT
    |-> ##[1:2] !CONVERSION_DONE_OUT) else $error("done not cleared");
  a_prime_span: assert property ($rose(CONVERSION_DONE_OUT)
    |-> run_r >= 16'd800) else $error("result too early");
  a_trig_start: assert property ($rose(CONVERSION_TRIGGER_IN) && MOD_RESET
    && !CONVERSION_DONE_OUT |-> ##[1:8] !MOD_RESET) else $error("trigger ignored");
  a_start_bit: assert property (WR && ADDR == 4'h0 && WDATA[0] && MOD_RESET
    && !CONVERSION_DONE_OUT |-> ##[1:4] !MOD_RESET) else $error("start ignored");
  a_stat_done: assert property (RD && ADDR == 4'h1 && CONVERSION_DONE_OUT
    |=> RDATA[0]) else $error("status done low");
endmodule : adcseq_top_sva

/* File: tb/adcseq_top_tb.sv */
// Purpose: Bench of the sequencer
// Assumes: Default period, 12-bit
// Notes: Reset after each continuous, multi and turbo run
`timescale 1ns/100ps
module adcseq_top_tb;
  import adcseq_pkg::*;
  logic CLK = 1'b0, SRST = 1'b1, trig = 1'b0, dma_en = 1'b0, DONE, MRST, dma_rd;
  adcseq_bus_s bus = '0;
  logic [15:0] RDATA, d;
  int failures = 0, num_checks = 0, cycles = 0, c, g;
  initial forever #12.5 CLK = ~CLK;
  adcseq_top uut (.CLK(CLK), .SRST(SRST), .ADDR(dma_rd ? 4'h2 : bus.addr),
    .WDATA(bus.wdata), .WR(bus.wr), .RD(bus.rd | dma_rd), .RDATA(RDATA), .MOD_DATA(12'h5a5),
    .CONVERSION_TRIGGER_IN(trig), .CONVERSION_DONE_OUT(DONE), .MOD_RESET(MRST));
  adcseq_dma_model dma (.clk(CLK), .en(dma_en), .done(DONE), .rd(dma_rd), .reads());
  task automatic stop_test;
    if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus_op(input logic [3:0] a, input logic [15:0] w, input logic wr);
    @(posedge CLK) bus <= '{a, w, wr, !wr};
    @(posedge CLK) bus <= '{a, w, 1'b0, 1'b0};
    @(negedge CLK) d = RDATA;
  endtask : bus_op
  task automatic wait_lvl(input logic lvl, inout int n);
    for (int i = 0; i < 2000 && DONE !== lvl; i++) begin
      @(negedge CLK);
      n++;
    end
    chk(DONE, lvl);
  endtask : wait_lvl
  task automatic do_reset;
    dma_en <= 1'b0;
    @(posedge CLK) SRST <= 1'b1;
    repeat (6) @(posedge CLK);
    SRST <= 1'b0;
  endtask : do_reset
  task automatic t_idle;
    bus_op(4'h1, 16'h0, 1'b0);
    chk(d, 16'h0004);
    bus_op(4'hf, 16'h0, 1'b0);
    chk(d, 16'h0);
    repeat (300) @(negedge CLK);
    chk({DONE, MRST}, 16'h1);
  endtask : t_idle
  task automatic t_single(input logic use_trig);
    if (use_trig) begin
      @(posedge CLK) trig <= 1'b1;
      repeat (3) @(posedge CLK);
      trig <= 1'b0;
    end else begin
      bus_op(4'h0, 16'h0011, 1'b1);
      bus_op(4'h1, 16'h0, 1'b0);
      chk(d, 16'h0002);
    end
    c = 0;
    wait_lvl(1'b1, c);
    chk(c inside {[830:850]}, 16'h1);
    bus_op(4'h1, 16'h0, 1'b0);
    chk(d, 16'h0007);
    bus_op(4'h2, 16'h0, 1'b0);
    chk(d, 16'h05a5);
    chk(DONE, 16'h0);
    repeat (1000) @(negedge CLK);
    chk({DONE, MRST}, 16'h1);
  endtask : t_single
  task automatic t_run(input logic [1:0] mode);
    dma_en <= 1'b1;
    bus_op(4'h0, {13'h0, mode, 1'b1}, 1'b1);
    c = 0;
    wait_lvl(1'b1, c);
    chk(c inside {[830:850]}, 16'h1);
    g = 0;
    wait_lvl(1'b0, g);
    wait_lvl(1'b1, g);
    if (mode == ADCSEQ_CONT) chk(16'(g), 16'd208);
    else chk(g >= 832, 16'h1);
    do_reset();
  endtask : t_run
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      stop_test();
    end
  end
  initial begin
    do_reset();
    t_idle();
    t_single(1'b1);
    t_single(1'b1);
    t_single(1'b0);
    t_run(ADCSEQ_CONT);
    t_run(ADCSEQ_MULTI);
    t_run(ADCSEQ_TURBO);
    stop_test();
  end
endmodule : adcseq_top_tb
bind adcseq_top adcseq_top_sva u_sva (.CLK(CLK), .SRST(SRST), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .CONVERSION_TRIGGER_IN(CONVERSION_TRIGGER_IN),
  .CONVERSION_DONE_OUT(CONVERSION_DONE_OUT), .MOD_RESET(MOD_RESET));
